// [core/fld_cfg.svh]
`ifndef FLD_CFG_SVH
`define FLD_CFG_SVH

`define FLD_CLK_PERIOD_NS 100
`define FLD_WAKE_US 200
`define FLD_WAKE_CYC ((`FLD_WAKE_US * 1000 + `FLD_CLK_PERIOD_NS - 1) / `FLD_CLK_PERIOD_NS)
`define FLD_LOW_US 200
`define FLD_LOW_CYC ((`FLD_LOW_US * 1000 + `FLD_CLK_PERIOD_NS - 1) / `FLD_CLK_PERIOD_NS)
`define FLD_SOFT_US 100
`define FLD_SOFT_CYC ((`FLD_SOFT_US * 1000 + `FLD_CLK_PERIOD_NS - 1) / `FLD_CLK_PERIOD_NS)
`define FLD_ONTIME_MS 3500
`define FLD_ONTIME_CYC ((64'd`FLD_ONTIME_MS * 64'd1000000) / 64'd`FLD_CLK_PERIOD_NS)
`define FLD_DROPOUT_CYC 32
`define FLD_FLASH_MV 9'h0A0
`define FLD_TORCH_MV 9'h03C
`define FLD_CODE_ZERO 5'h00
`define FLD_CODE_STEP 5'h01
`define FLD_CODE_MAX 5'h1F
`define FLD_CODE_LIMIT 5'h08

`endif

// [core/fld_pkg.sv]
package fld_pkg;

    typedef enum logic [2:0] {
        ST_OFF  = 3'b000,
        ST_WAKE = 3'b001,
        ST_SOFT = 3'b011,
        ST_RUN  = 3'b010,
        ST_HOT  = 3'b110
    } fld_state_t;

    typedef enum logic [1:0] {
        PH_IDLE  = 2'b00,
        PH_AWAKE = 2'b01,
        PH_PROG  = 2'b11
    } fld_phase_t;

    typedef struct packed {
        logic flash_sel;
        logic driver_on;
        logic pulse_level;
        logic over_temp;
        logic fb_below;
    } fld_pins_t;

    typedef struct packed {
        logic converter_en;
        logic switches_on;
        logic soft_start;
        logic doubler_pump_mode;
        logic timed_out;
        logic [8:0] target_mv;
        logic [4:0] feedback_setpoint;
    } fld_status_t;

endpackage

// [core/fld_timer.sv]
`timescale 1ns/100ps

module fld_timer #(
    parameter int WIDTH = 12,
    parameter int unsigned LIMIT = 2000
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic run,
    output logic done
);

    generate
        if (LIMIT == 0 || WIDTH > 31 || LIMIT >= (32'd1 << WIDTH)) begin : g_bad
            $error("fld_timer: LIMIT does not fit WIDTH");
        end
    endgenerate

    logic [WIDTH-1:0] cnt_reg;
    logic [WIDTH-1:0] cnt_next;

    assign done = (cnt_reg == WIDTH'(LIMIT));

    // saturates at the limit so done stays up until cleared
    always_comb begin
        cnt_next = cnt_reg;
        if (clear) begin
            cnt_next = '0;
        end else if (run && !done) begin
            cnt_next = cnt_reg + WIDTH'(1);
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

endmodule

// [core/fld_ctrl.sv]
`timescale 1ns/100ps
`include "fld_cfg.svh"

// What this block does, and what its host must do
// R1 - fixed variant: flash-select high means 160mV target, low means 60mV.
// R2 - fixed variant: run while driver-on high, stop at once when low.
// R3 - undriven driver-on reads low, so the driver stays shut down.
// R4 - fixed variant: flash mode on-time limited to 3.5s, then shutdown.
// R5 - after timeout, flash-select or driver-on activity re-enables the driver.
// R6 - after timeout, flash mode needs driver-on low then high again.
// R7 - on enable wait 200us for reference wake, then soft-start.
// R8 - start in 1X; go 2X after feedback low over 32 cycles.
// R9 - stay 2X until driver-on toggle, flash fall, supply cycle, thermal fault.
// R10 - leaving 2X returns to 1X and soft-starts again.
// R11 - pulse variant: each counted rising edge raises setpoint one step, max 31.
// R12 - pulse variant: pulse input low over 200us means shutdown.
// R13 - edge 1 wakes, edge 2 sets zero, edge 3 sets 58mV, then steps.
// R14 - setpoint saturates at maximum; extra edges ignored until shutdown.
// R15 - setpoint only rises; lowering needs shutdown and reprogramming.
// R16 - pulse variant: 3.5s on-time limit when setpoint is 120mV or more.
// R17 - over-temperature turns switches off; on clearing, recover with soft-start.
// R18 - host always drives flash-select and pulse input, never floating.
// R19 - all timers count cycles of the block clock.
// R20 - host holds pulse input high to keep the programmed setpoint.
// R21 - host gives first edge at least 600us after power-up.
// R22 - host spaces first and second pulses about 25us, at most 75us.
// R23 - host pulse train no faster than 1MHz.
module fld_ctrl #(
    parameter int unsigned ONTIME_CYC = 32'(`FLD_ONTIME_CYC),
    parameter int ONTIME_W = 26
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic pulse_variant,
    input wire fld_pkg::fld_pins_t pins,
    output fld_pkg::fld_status_t status
);

    generate
        if (ONTIME_CYC < 2 || ONTIME_W > 31 || ONTIME_CYC >= (32'd1 << ONTIME_W)) begin : g_bad
            $error("fld_ctrl: ONTIME_CYC does not fit ONTIME_W");
        end
    endgenerate

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    fld_pkg::fld_pins_t meta_reg;
    fld_pkg::fld_pins_t sync_reg;
    fld_pkg::fld_pins_t prev_reg;
    logic variant_meta_reg;
    logic variant_reg;

    // a floating driver-on is pulled low outside, so it arrives here as low [R3]
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
            variant_meta_reg <= 1'b0;
            variant_reg <= 1'b0;
        end else begin
            meta_reg <= pins;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
            variant_meta_reg <= pulse_variant;
            variant_reg <= variant_meta_reg;
        end
    end

    logic drv;
    logic flash;
    logic hot;
    logic drv_rise;
    logic drv_fall;
    logic flash_fall;
    logic flash_change;
    logic pulse_rise;

    assign drv = sync_reg.driver_on && !variant_reg;
    assign flash = sync_reg.flash_sel;
    assign hot = sync_reg.over_temp;
    assign drv_rise = sync_reg.driver_on && !prev_reg.driver_on;
    assign drv_fall = !sync_reg.driver_on && prev_reg.driver_on;
    assign flash_fall = !sync_reg.flash_sel && prev_reg.flash_sel;
    assign flash_change = sync_reg.flash_sel != prev_reg.flash_sel;
    assign pulse_rise = sync_reg.pulse_level && !prev_reg.pulse_level;

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    fld_pkg::fld_state_t state_reg;
    fld_pkg::fld_state_t state_next;
    fld_pkg::fld_phase_t phase_reg;
    fld_pkg::fld_phase_t phase_next;
    logic [4:0] code_reg;
    logic [4:0] code_next;
    logic timeout_reg;
    logic timeout_next;
    logic lock_reg;
    logic lock_next;
    logic doubler_reg;
    logic doubler_next;
    fld_pkg::fld_status_t status_reg;
    fld_pkg::fld_status_t status_next;

    // ------------------------------------------------------------
    // timers
    // ------------------------------------------------------------
    logic wake_done;
    logic soft_done;
    logic drop_done;
    logic low_done;
    logic ontime_done;
    logic limited;
    logic on_state;

    assign on_state = state_reg != fld_pkg::ST_OFF;
    // on-time is only limited for flash mode or a high programmed setpoint
    assign limited = variant_reg ? (code_reg >= `FLD_CODE_LIMIT) : (flash && !lock_reg);

    fld_timer #(.WIDTH(12), .LIMIT(`FLD_WAKE_CYC)) u_wake (
        .mclk(mclk),
        .reset_n(reset_n),
        .clear(state_reg != fld_pkg::ST_WAKE),
        .run(1'b1),
        .done(wake_done)
    ); // [R7] [R19]

    fld_timer #(.WIDTH(12), .LIMIT(`FLD_SOFT_CYC)) u_soft (
        .mclk(mclk),
        .reset_n(reset_n),
        .clear(state_reg != fld_pkg::ST_SOFT),
        .run(1'b1),
        .done(soft_done)
    ); // [R7]

    // more than 32 cycles below target: the 33rd low cycle trips it
    fld_timer #(.WIDTH(6), .LIMIT(`FLD_DROPOUT_CYC + 1)) u_drop (
        .mclk(mclk),
        .reset_n(reset_n),
        .clear(!sync_reg.fb_below || state_reg != fld_pkg::ST_RUN || doubler_reg),
        .run(1'b1),
        .done(drop_done)
    ); // [R8]

    // longer than 200us low, so one cycle past the count
    fld_timer #(.WIDTH(12), .LIMIT(`FLD_LOW_CYC + 1)) u_low (
        .mclk(mclk),
        .reset_n(reset_n),
        .clear(sync_reg.pulse_level || !variant_reg || phase_reg == fld_pkg::PH_IDLE),
        .run(1'b1),
        .done(low_done)
    ); // [R12] [R19]

    fld_timer #(.WIDTH(ONTIME_W), .LIMIT(ONTIME_CYC)) u_ontime (
        .mclk(mclk),
        .reset_n(reset_n),
        .clear(!on_state || !limited),
        .run(1'b1),
        .done(ontime_done)
    ); // [R4] [R16] [R19]

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    logic run_ok;
    logic exit_2x;

    always_comb begin
        phase_next = phase_reg;
        code_next = code_reg;
        timeout_next = timeout_reg;
        lock_next = lock_reg;
        state_next = state_reg;
        run_ok = 1'b0;
        exit_2x = 1'b0;

        // pulse-programmed setpoint decode
        if (!variant_reg || low_done) begin
            phase_next = fld_pkg::PH_IDLE; // [R12] [R15]
            code_next = `FLD_CODE_ZERO;
        end else if (pulse_rise) begin
            unique case (phase_reg)
                fld_pkg::PH_IDLE: begin
                    phase_next = fld_pkg::PH_AWAKE; // [R13]
                    code_next = `FLD_CODE_ZERO;
                end
                fld_pkg::PH_AWAKE: begin
                    phase_next = fld_pkg::PH_PROG; // [R13]
                    code_next = `FLD_CODE_ZERO;
                end
                fld_pkg::PH_PROG: begin
                    // only ever steps upward, stops at full scale [R11] [R14] [R15]
                    if (code_reg != `FLD_CODE_MAX) begin
                        code_next = code_reg + `FLD_CODE_STEP;
                    end
                end
                default: begin
                    phase_next = fld_pkg::PH_IDLE;
                end
            endcase
        end

        // timeout hold: the set has priority over every release path
        if (ontime_done && on_state) begin
            timeout_next = 1'b1; // [R4] [R16]
        end else if (variant_reg ? low_done : (flash_change || drv_rise)) begin
            timeout_next = 1'b0; // [R5] [R12]
        end

        // flash lock only lifts after driver-on has been seen low
        if (ontime_done && on_state && !variant_reg) begin
            lock_next = 1'b1; // [R6]
        end else if (!sync_reg.driver_on) begin
            lock_next = 1'b0; // [R6]
        end

        if (variant_reg) begin
            run_ok = phase_reg != fld_pkg::PH_IDLE && !timeout_reg && !low_done;
        end else begin
            run_ok = drv && !timeout_reg && !(lock_reg && flash); // [R2] [R6]
            exit_2x = drv_rise || drv_fall || flash_fall; // [R9]
        end
        if (ontime_done) begin
            run_ok = 1'b0; // [R4] [R16]
        end

        unique case (state_reg)
            fld_pkg::ST_OFF: begin
                if (run_ok) begin
                    state_next = fld_pkg::ST_WAKE; // [R7]
                end
            end
            fld_pkg::ST_WAKE: begin
                if (!run_ok) begin
                    state_next = fld_pkg::ST_OFF; // [R2]
                end else if (wake_done) begin
                    state_next = fld_pkg::ST_SOFT; // [R7]
                end
            end
            fld_pkg::ST_SOFT: begin
                if (!run_ok) begin
                    state_next = fld_pkg::ST_OFF; // [R2]
                end else if (hot) begin
                    state_next = fld_pkg::ST_HOT; // [R17]
                end else if (soft_done) begin
                    state_next = fld_pkg::ST_RUN; // [R7]
                end
            end
            fld_pkg::ST_RUN: begin
                if (!run_ok) begin
                    state_next = fld_pkg::ST_OFF; // [R2]
                end else if (hot) begin
                    state_next = fld_pkg::ST_HOT; // [R17]
                end else if (exit_2x && doubler_reg) begin
                    state_next = fld_pkg::ST_SOFT; // [R10]
                end
            end
            fld_pkg::ST_HOT: begin
                if (!run_ok) begin
                    state_next = fld_pkg::ST_OFF;
                end else if (!hot) begin
                    state_next = fld_pkg::ST_SOFT; // [R17]
                end
            end
            default: begin
                state_next = fld_pkg::ST_OFF;
            end
        endcase

        // 2X holds only while regulating; any exit drops back to 1X [R8] [R9] [R10]
        doubler_next = (state_next == fld_pkg::ST_RUN) && (doubler_reg || drop_done);
    end

    // ------------------------------------------------------------
    // outputs, computed from next values so they match the state
    // ------------------------------------------------------------
    always_comb begin
        status_next = '0;
        status_next.converter_en = state_next != fld_pkg::ST_OFF;
        status_next.switches_on = state_next == fld_pkg::ST_SOFT
                               || state_next == fld_pkg::ST_RUN; // [R17]
        status_next.soft_start = state_next == fld_pkg::ST_SOFT;
        status_next.doubler_pump_mode = doubler_next;
        status_next.timed_out = timeout_next;
        status_next.feedback_setpoint = code_next;
        if (!variant_reg) begin
            status_next.target_mv = flash ? `FLD_FLASH_MV : `FLD_TORCH_MV; // [R1]
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= fld_pkg::ST_OFF;
            phase_reg <= fld_pkg::PH_IDLE;
            code_reg <= `FLD_CODE_ZERO;
            timeout_reg <= 1'b0;
            lock_reg <= 1'b0;
            doubler_reg <= 1'b0;
            status_reg <= '0;
        end else begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            code_reg <= code_next;
            timeout_reg <= timeout_next;
            lock_reg <= lock_next;
            doubler_reg <= doubler_next;
            status_reg <= status_next;
        end
    end

    assign status = status_reg;

endmodule

// [tb/fld_ctrl_properties.sv]
`timescale 1ns/100ps
module fld_ctrl_properties #(
    parameter int unsigned ONTIME_CYC = 200
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic pulse_variant,
    input wire fld_pkg::fld_pins_t pins,
    input wire fld_pkg::fld_status_t status
);
    logic [11:0] low_reg;
    logic [11:0] wake_reg;
    logic [5:0] fb_reg;
    logic [31:0] lim_reg;
    logic was_on_reg;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    // ----------------------------------------
    // helper counters
    // ----------------------------------------
    // limit counted in run only, so a design that starts its timer earlier still passes
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            low_reg <= 12'h000;
            wake_reg <= 12'h000;
            fb_reg <= 6'h00;
            lim_reg <= 32'h0;
            was_on_reg <= 1'b0;
        end else begin
            low_reg <= pins.pulse_level ? 12'h000 : low_reg + 12'(low_reg != 12'hFFF);
            fb_reg <= pins.fb_below ? fb_reg + 6'(fb_reg != 6'h3F) : 6'h00;
            wake_reg <= (status.converter_en && !status.switches_on) ? wake_reg + 12'h001 : 12'h000;
            lim_reg <= (status.switches_on && !status.soft_start && (pulse_variant ?
                (status.feedback_setpoint >= 5'h08) : pins.flash_sel)) ? lim_reg + 32'h1 : 32'h0;
            was_on_reg <= status.converter_en && (was_on_reg || status.switches_on);
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    a_off_quiet: assert property (!status.converter_en |-> !status.switches_on
        && !status.doubler_pump_mode) else $error("outputs active while off");
    a_enable_low: assert property ((!pulse_variant && !pins.driver_on)[*5]
        |-> !status.converter_en) else $error("converter on with enable low");
    a_level_target: assert property ((!pulse_variant && $stable(pins.flash_sel))[*5]
        |-> status.target_mv == (pins.flash_sel ? 9'h0A0 : 9'h03C)) else $error("bad target");
    a_wake_length: assert property ($rose(status.switches_on) && !was_on_reg
        |-> wake_reg inside {[12'h7CE:12'h7D2]}) else $error("wake delay wrong");
    a_soft_entry: assert property ($rose(status.switches_on)
        |-> status.soft_start) else $error("switches on without soft start");
    a_dropout_wait: assert property ($rose(status.doubler_pump_mode)
        |-> fb_reg >= 6'h21) else $error("doubler too early");
    a_doubler_hold: assert property ((!pulse_variant && pins.driver_on && !pins.over_temp
        && !$fell(pins.flash_sel))[*5] ##0 status.doubler_pump_mode
        |=> status.doubler_pump_mode || status.timed_out) else $error("doubler lost");
    a_doubler_exit: assert property ($fell(status.doubler_pump_mode)
        |-> status.soft_start || !status.switches_on) else $error("exit without soft start");
    a_hot_off: assert property (pins.over_temp[*5] |-> !status.switches_on)
        else $error("switches on while hot");
    a_code_step: assert property ($changed(status.feedback_setpoint)
        |-> status.feedback_setpoint == $past(status.feedback_setpoint) + 5'h01
        || status.feedback_setpoint == 5'h00) else $error("setpoint jump");
    a_low_off: assert property (pulse_variant && low_reg == 12'h7DA
        |-> !status.converter_en && status.feedback_setpoint == 5'h00) else $error("no shutdown");
    a_ontime_cap: assert property (lim_reg <= ONTIME_CYC + 8)
        else $error("on-time limit exceeded");

    c_doubler: cover property ($rose(status.doubler_pump_mode));
    c_timeout: cover property ($rose(status.timed_out));
    c_code_max: cover property (status.feedback_setpoint == 5'h1F);
endmodule

bind fld_ctrl fld_ctrl_properties #(.ONTIME_CYC(ONTIME_CYC)) fld_ctrl_properties_inst (
    .mclk(mclk),
    .reset_n(reset_n),
    .pulse_variant(pulse_variant),
    .pins(pins),
    .status(status)
);

// [tb/fld_host_model.sv]
`timescale 1ns/100ps
// ----------------------------------------
// host side of the control pins
// ----------------------------------------
module fld_host_model (
    input wire logic mclk,
    input wire logic flash_req,
    input wire logic on_req,
    input wire logic hot_req,
    input wire logic fb_req,
    output fld_pkg::fld_pins_t pins
);
    logic pulse_reg = 1'b0;

    // every pin always driven, none floats
    assign pins = {flash_req, on_req, pulse_reg, hot_req, fb_req};

    // 5 low then 5 high is 1MHz, the fastest allowed left high to keep the code
    task automatic send_pulses(input int n);
        repeat (n) begin
            @(negedge mclk);
            pulse_reg = 1'b0;
            repeat (5) @(negedge mclk);
            pulse_reg = 1'b1;
            repeat (4) @(negedge mclk);
        end
    endtask

    // stays low afterwards: raising here would be a counted edge
    task automatic hold_low(input int c);
        @(negedge mclk);
        pulse_reg = 1'b0;
        repeat (c) @(negedge mclk);
    endtask
endmodule

// [tb/fld_ctrl_tb.sv]
`timescale 1ns/100ps
module fld_ctrl_tb;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic pulse_variant = 1'b0;
    logic flash_req = 1'b0;
    logic on_req = 1'b0;
    logic hot_req = 1'b0;
    logic fb_req = 1'b0;
    fld_pkg::fld_pins_t pins;
    fld_pkg::fld_status_t status;
    int n_errors = 0;
    int check_count = 0;

    always #50 mclk = ~mclk;

    fld_host_model fld_host_model_inst (.mclk(mclk), .flash_req(flash_req), .on_req(on_req),
        .hot_req(hot_req), .fb_req(fb_req), .pins(pins));
    fld_ctrl #(.ONTIME_CYC(200)) fld_ctrl_inst (.mclk(mclk), .reset_n(reset_n),
        .pulse_variant(pulse_variant), .pins(pins), .status(status));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [18:0] seen, input logic [18:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic wait_bit(input int idx, input int lim);
        for (int i = 0; i < lim && status[idx] !== 1'b1; i++) cyc(1);
    endtask

    task automatic pulse(input int n);
        fld_host_model_inst.send_pulses(n);
    endtask

    task automatic do_reset(input logic pv);
        reset_n = 1'b0;
        pulse_variant = pv;
        flash_req = 1'b0;
        on_req = 1'b0;
        cyc(8);
        reset_n = 1'b1;
        cyc(10);
        check("idle", status, pv ? 19'h00000 : {5'h00, 9'h03C, 5'h00});
    endtask

    task automatic print_verdict();
        $display("checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_fixed();
        do_reset(1'b0);
        on_req = 1'b1;
        cyc(5);
        check("wake", status[18:16], 3'b100);
        check("torch", status.target_mv, 9'h03C);
        cyc(1990);
        check("early soft", status.soft_start, 1'b0);
        cyc(20);
        check("soft", status[18:16], 3'b111);
        cyc(1400);
        check("torch long", status[18:14], 5'b11000);
        flash_req = 1'b1;
        cyc(5);
        check("flash", status.target_mv, 9'h0A0);
        wait_bit(14, 300);
        check("timeout", status[18:14], 5'b00001);
        flash_req = 1'b0;
        cyc(5);
        check("release", status[18:14], 5'b10000);
        flash_req = 1'b1;
        cyc(5);
        check("refuse", status.converter_en, 1'b0);
        on_req = 1'b0;
        cyc(5);
        on_req = 1'b1;
        cyc(5);
        check("restart", status.converter_en, 1'b1);
    endtask

    task automatic t_doubler();
        do_reset(1'b0);
        on_req = 1'b1;
        cyc(3020);
        fb_req = 1'b1;
        cyc(20);
        check("no dbl", status.doubler_pump_mode, 1'b0);
        cyc(20);
        fb_req = 1'b0;
        check("dbl", status.doubler_pump_mode, 1'b1);
        flash_req = 1'b1;
        cyc(10);
        check("dbl kept", status.doubler_pump_mode, 1'b1);
        flash_req = 1'b0;
        cyc(5);
        check("flash fall", status[17:15], 3'b110);
        cyc(1010);
        fb_req = 1'b1;
        cyc(40);
        fb_req = 1'b0;
        hot_req = 1'b1;
        cyc(5);
        check("hot", status[18:15], 4'b1000);
        hot_req = 1'b0;
        cyc(5);
        check("cool", status[18:15], 4'b1110);
        on_req = 1'b0;
        cyc(5);
        check("off", status[18:15], 4'b0000);
    endtask

    task automatic t_pulse();
        do_reset(1'b1);
        cyc(6000);
        pulse(1);
        cyc(5);
        check("wake", status.converter_en, 1'b1);
        cyc(235);
        pulse(1);
        cyc(5);
        check("zero", status.feedback_setpoint, 5'h00);
        pulse(1);
        cyc(5);
        check("58mV", status.feedback_setpoint, 5'h01);
        fld_host_model_inst.hold_low(100);
        pulse(6);
        cyc(4000);
        check("code 7", status[18:14], 5'b11000);
        check("code 7", status.feedback_setpoint, 5'h07);
        pulse(1);
        wait_bit(14, 500);
        check("limit", status[18:14], 5'b00001);
        check("kept", status.feedback_setpoint, 5'h08);
        fld_host_model_inst.hold_low(2010);
        cyc(5);
        check("shutdown", status, 19'h00000);
        pulse(1);
        cyc(240);
        pulse(40);
        check("max", status.feedback_setpoint, 5'h1F);
    endtask

    initial begin
        t_fixed();
        t_doubler();
        t_pulse();
        print_verdict();
    end

    initial begin
        repeat (60000) @(posedge mclk);
        n_errors++;
        print_verdict();
    end
endmodule
